//--- board_model.sv
// board model: sequences the reset, step, power-save and interrupt pins
// assumes: tasks called by the testbench; setup_cycles may be shortened
`timescale 1ns/100ps
`default_nettype none
module board_model #(
    parameter int setup_cycles = 100000,
    parameter int hold_cycles = 100
) (
    input wire logic clock,
    output logic reset_n_pin,
    output logic single_step_n_pin,
    output logic power_save_n_pin,
    output logic interrupt_n_pin
);
    initial begin
        {reset_n_pin, single_step_n_pin, power_save_n_pin, interrupt_n_pin} = 4'hf;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // {reset, interrupt} levels, whatever the power-save level; also driven in power-down
    task automatic drive(input logic [1:0] v);
        wait_n(1);
        {reset_n_pin, interrupt_n_pin} = v;
    endtask
    task automatic enter_pd(input logic ram);
        wait_n(1);
        if (ram)
            reset_n_pin = 1'h0;
        else
            single_step_n_pin = 1'h0;
        wait_n(setup_cycles);
        power_save_n_pin = 1'h0;
    endtask
    task automatic leave_pd;
        wait_n(1);
        power_save_n_pin = 1'h1;
        wait_n(hold_cycles);
        reset_n_pin = 1'h1;
        single_step_n_pin = 1'h1;
    endtask
endmodule
`default_nettype wire

//--- freeze_if.sv
// interface: freeze request and pin-hold controls between the mode fsm and pin holder
// assumes: both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface freeze_if;
    logic clocks_stopped;
    logic pins_floated;
    logic resume_vector;
    modport ctrl (output clocks_stopped, output pins_floated, output resume_vector);
    modport hold (input clocks_stopped, input pins_floated, input resume_vector);
endinterface
`default_nettype wire

//--- halt_and_power_down_control.sv
// halt and power-down control: halt opcode, interrupt/reset release, pin-driven power-down
// assumes: core presents opcode at each execute strobe; board drives reset, step,
// power-save and interrupt pins asynchronously
//
// Notes on behaviour
// [RQ1] opcode 01h at execute puts the core into halt.
// [RQ2] in halt the oscillator runs but internal clock enables stop and state is held.
// [RQ3] reset while halted leaves halt, resets and restarts at address 000h.
// [RQ4] interrupt wake with interrupts enabled runs one more instruction then services it.
// [RQ5] interrupt wake with interrupts disabled resumes after halt with no service.
// [RQ6] data bus and both port groups keep their pre-halt values during halt.
// [RQ7] test pin zero keeps its pre-halt status during halt.
// [RQ8] board lowers reset before power-save to enter ram-retention power-down.
// [RQ9] board holds reset low 10 ms before lowering power-save.
// [RQ10] board keeps reset low 10 us after power-save rises.
// [RQ11] leaving ram-retention power-down restarts through initialisation at address 0.
// [RQ12] board lowers single-step before power-save to enter full-retention power-down.
// [RQ13] leaving full-retention power-down resumes exactly from the held state.
// [RQ14] in power-down reset and step inputs are disabled and their pull-ups are off.
// [RQ15] in power-down test pin zero floats and its input path is disabled.
// [RQ16] the active-low interrupt pin only starts service when enabled; reset disables it.
`timescale 1ns/100ps
`default_nettype none
module halt_and_power_down_control
    import lowpower_pkg::*;
#(
    parameter int bus_width = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_n_pin,
    input wire logic single_step_n_pin,
    input wire logic power_save_n_pin,
    input wire logic interrupt_n_pin,
    input wire logic test_pin_zero_in,
    input wire logic exec_strobe,
    input wire logic [7:0] exec_opcode,
    input wire logic enable_interrupts,
    input wire logic disable_interrupts,
    input wire logic [bus_width-1:0] core_data_bus,
    input wire logic core_data_bus_oe,
    input wire logic [7:0] core_port_one,
    input wire logic [7:0] core_port_two,
    input wire logic core_test_pin_zero,
    input wire logic core_test_pin_zero_oe,
    output logic core_clock_enable,
    output logic core_reset,
    output logic [11:0] restart_address,
    output logic take_interrupt,
    output logic interrupts_enabled_state,
    output logic oscillator_run,
    output logic reset_pullup_on,
    output logic step_pullup_on,
    output logic test_pin_zero_sampled,
    output logic [bus_width-1:0] data_bus_lines_out,
    output logic data_bus_lines_oe,
    output logic [7:0] port_one_lines_out,
    output logic port_one_lines_oe,
    output logic [7:0] port_two_lines_out,
    output logic port_two_lines_oe,
    output logic test_pin_zero_out,
    output logic test_pin_zero_oe,
    output mode_t mode
);
    initial begin
        if (bus_width != 8) begin
            $error("halt_and_power_down_control: bus_width must be 8");
        end
    end

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_a <= 5'h1f;
            sync_b <= 5'h1f;
        end else begin
            sync_a <= {reset_n_pin, single_step_n_pin, power_save_n_pin,
                       interrupt_n_pin, test_pin_zero_in};
            sync_b <= sync_a;
        end
    end

    logic reset_low;
    logic step_low;
    logic save_low;
    logic irq_low;
    logic pd_mode;
    // reset and step are ignored while the oscillator is stopped
    assign pd_mode = (mode == st_pd_ram) || (mode == st_pd_all);
    assign reset_low = !sync_b[4] && !(pd_mode && save_low); // RQ14
    assign step_low = !sync_b[3] && !(pd_mode && save_low); // RQ14
    assign save_low = !sync_b[2];
    assign irq_low = !sync_b[1];

    // -----------------------------------------------------------------
    // interrupt enable state
    // -----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || reset_low) begin
            interrupts_enabled_state <= 1'b0; // RQ16
        end else if (core_clock_enable && enable_interrupts) begin
            interrupts_enabled_state <= 1'b1;
        end else if (core_clock_enable && disable_interrupts) begin
            interrupts_enabled_state <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // mode state machine
    // -----------------------------------------------------------------
    mode_t next_mode;
    logic wake_pending;
    logic ram_reset_pending;

    always_comb begin
        next_mode = mode;
        case (mode)
            st_run: begin
                if (save_low && reset_low) begin
                    next_mode = st_pd_ram; // RQ8
                end else if (save_low && step_low) begin
                    next_mode = st_pd_all; // RQ12
                end else if (exec_strobe && is_halt(exec_opcode)) begin
                    next_mode = st_halt; // RQ1
                end
            end
            st_halt: begin
                if (reset_low) begin
                    next_mode = st_run; // RQ3
                end else if (irq_low && interrupts_enabled_state) begin
                    next_mode = st_step_after_halt; // RQ4
                end else if (irq_low) begin
                    next_mode = st_run; // RQ5
                end
            end
            st_step_after_halt: begin
                // one instruction runs before the service entry
                if (reset_low) begin
                    next_mode = st_run;
                end else if (exec_strobe) begin
                    next_mode = st_run; // RQ4
                end
            end
            st_pd_ram: begin
                if (!save_low) begin
                    next_mode = st_run; // RQ11
                end
            end
            st_pd_all: begin
                if (!save_low && !step_low) begin
                    next_mode = st_run; // RQ13
                end
            end
            default: begin
                next_mode = st_run;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode <= st_run;
        end else begin
            mode <= next_mode;
        end
    end

    // interrupt service request: one pulse at the end of the extra instruction
    always_ff @(posedge clock) begin
        if (rst) begin
            wake_pending <= 1'b0;
        end else begin
            wake_pending <= (mode == st_step_after_halt) && exec_strobe && !reset_low; // RQ4
        end
    end

    // in run mode an enabled low interrupt also requests service
    always_comb begin
        take_interrupt = wake_pending
            || (mode == st_run && irq_low && interrupts_enabled_state); // RQ16
    end

    // leaving ram-retention power-down forces a reset until the reset pin is released
    always_ff @(posedge clock) begin
        if (rst) begin
            ram_reset_pending <= 1'b0;
        end else if (mode == st_pd_ram) begin
            ram_reset_pending <= 1'b1; // RQ11
        end else if (!reset_low) begin
            ram_reset_pending <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // core controls
    // -----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            core_clock_enable <= 1'b1;
            core_reset <= 1'b1;
            restart_address <= reset_vector;
            oscillator_run <= 1'b1;
            reset_pullup_on <= 1'b1;
            step_pullup_on <= 1'b1;
        end else begin
            // internal clocks stop in halt and power-down; held state stays
            core_clock_enable <= (next_mode == st_run) || (next_mode == st_step_after_halt)
                && !step_low; // RQ2 RQ13
            core_reset <= reset_low || ram_reset_pending; // RQ3 RQ11
            restart_address <= reset_vector; // RQ3 RQ11
            oscillator_run <= !(pd_mode && save_low);
            reset_pullup_on <= !(pd_mode && save_low); // RQ14
            step_pullup_on <= !(pd_mode && save_low); // RQ14
        end
    end

    // test pin zero input path is cut while powered down
    always_ff @(posedge clock) begin
        if (rst) begin
            test_pin_zero_sampled <= 1'b0;
        end else if (!pd_mode) begin
            test_pin_zero_sampled <= sync_b[0]; // RQ15
        end
    end

    // -----------------------------------------------------------------
    // pin holders
    // -----------------------------------------------------------------
    freeze_if fz ();
    assign fz.clocks_stopped = (mode == st_halt) || pd_mode; // RQ6 RQ7
    assign fz.pins_floated = pd_mode; // RQ15
    assign fz.resume_vector = ram_reset_pending;

    pin_hold #(.width(bus_width)) data_hold (
        .clock(clock),
        .rst(rst),
        .fz(fz),
        .core_value(core_data_bus),
        .core_enable(core_data_bus_oe),
        .reset_value(bus_reset_value),
        .pin_out(data_bus_lines_out),
        .pin_oe(data_bus_lines_oe)
    );

    pin_hold #(.width(8)) port_one_hold (
        .clock(clock),
        .rst(rst),
        .fz(fz),
        .core_value(core_port_one),
        .core_enable(1'b1),
        .reset_value(port_reset_value),
        .pin_out(port_one_lines_out),
        .pin_oe(port_one_lines_oe)
    );

    pin_hold #(.width(8)) port_two_hold (
        .clock(clock),
        .rst(rst),
        .fz(fz),
        .core_value(core_port_two),
        .core_enable(1'b1),
        .reset_value(port_reset_value),
        .pin_out(port_two_lines_out),
        .pin_oe(port_two_lines_oe)
    );

    pin_hold #(.width(1)) test_zero_hold (
        .clock(clock),
        .rst(rst),
        .fz(fz),
        .core_value(core_test_pin_zero),
        .core_enable(core_test_pin_zero_oe),
        .reset_value(1'b0),
        .pin_out(test_pin_zero_out),
        .pin_oe(test_pin_zero_oe)
    );
endmodule
`default_nettype wire

//--- hpd_chk.sv
// checker: timing relations at the halt and power-down block's ports
// assumes: one clock, synchronous active-high reset, bound to the block below
`timescale 1ns/100ps
`default_nettype none
module hpd_chk
    import lowpower_pkg::*;
#(
    parameter int bus_width = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_n_pin,
    input wire logic power_save_n_pin,
    input wire logic interrupt_n_pin,
    input wire logic exec_strobe,
    input wire logic [7:0] exec_opcode,
    input wire logic core_clock_enable,
    input wire logic core_reset,
    input wire logic [11:0] restart_address,
    input wire logic take_interrupt,
    input wire logic interrupts_enabled_state,
    input wire logic oscillator_run,
    input wire logic reset_pullup_on,
    input wire logic step_pullup_on,
    input wire logic test_pin_zero_sampled,
    input wire logic [bus_width-1:0] data_bus_lines_out,
    input wire logic [7:0] port_one_lines_out,
    input wire logic [7:0] port_two_lines_out,
    input wire logic test_pin_zero_out,
    input wire logic test_pin_zero_oe,
    input wire mode_t mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_HALT_ENTRY: assert property (
        mode == st_run && exec_strobe && exec_opcode == halt_opcode && reset_n_pin
        && power_save_n_pin |=> mode == st_halt && !core_clock_enable)
        else $error("halt opcode not taken");
    AST_HALT_FREEZE: assert property (
        mode == st_halt && $past(mode) == st_halt |-> oscillator_run && !core_clock_enable
        && $stable({data_bus_lines_out, port_one_lines_out, port_two_lines_out})
        && $stable({test_pin_zero_out, test_pin_zero_oe}))
        else $error("state moved while halted");
    AST_RESET_WAKE: assert property (
        mode == st_halt && !reset_n_pin |-> ##[1:4]
        mode == st_run && core_reset && restart_address == reset_vector)
        else $error("reset did not end halt");
    AST_WAKE_DI: assert property (
        mode == st_halt && !interrupts_enabled_state && !interrupt_n_pin && reset_n_pin
        |-> ##[1:4] mode == st_run && !take_interrupt)
        else $error("disabled wake wrong");
    AST_WAKE_EI: assert property (
        mode == st_halt && interrupts_enabled_state && !interrupt_n_pin && reset_n_pin
        |-> ##[1:4] mode == st_step_after_halt)
        else $error("enabled wake wrong");
    AST_STEP_IRQ: assert property (
        mode == st_step_after_halt && exec_strobe |=> mode == st_run ##[0:1] take_interrupt)
        else $error("no service after one step");
    // outputs are registered from the mode of the cycle before, so they lag one edge
    AST_PD_PINS: assert property (
        (mode == st_pd_ram || mode == st_pd_all) |=> !test_pin_zero_oe
        && $stable(test_pin_zero_sampled))
        else $error("power-down test pin wrong");
    // power-save reaches the logic through two flops, hence the depth of two
    AST_PD_OSC: assert property (
        (mode == st_pd_ram || mode == st_pd_all) && !$past(power_save_n_pin, 2)
        |=> !oscillator_run && !reset_pullup_on && !step_pullup_on)
        else $error("power-down oscillator or pull-ups wrong");
    AST_PD_ALL_HOLD: assert property (
        mode == st_pd_all && !power_save_n_pin |=> mode == st_pd_all && !core_reset)
        else $error("full retention left early");
    AST_PD_EXIT: assert property (
        !$past(rst) && ($past(mode) == st_pd_ram || $past(mode) == st_pd_all)
        && mode != $past(mode) |-> mode == st_run
        && core_reset == ($past(mode) == st_pd_ram) && restart_address == reset_vector)
        else $error("power-down exit wrong");
endmodule
bind halt_and_power_down_control hpd_chk #(.bus_width(bus_width)) i_chk (
    .clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
    .power_save_n_pin(power_save_n_pin), .interrupt_n_pin(interrupt_n_pin),
    .exec_strobe(exec_strobe), .exec_opcode(exec_opcode),
    .core_clock_enable(core_clock_enable), .core_reset(core_reset),
    .restart_address(restart_address), .take_interrupt(take_interrupt),
    .interrupts_enabled_state(interrupts_enabled_state), .oscillator_run(oscillator_run),
    .reset_pullup_on(reset_pullup_on), .step_pullup_on(step_pullup_on),
    .test_pin_zero_sampled(test_pin_zero_sampled), .data_bus_lines_out(data_bus_lines_out),
    .port_one_lines_out(port_one_lines_out), .port_two_lines_out(port_two_lines_out),
    .test_pin_zero_out(test_pin_zero_out), .test_pin_zero_oe(test_pin_zero_oe),
    .mode(mode)
);
`default_nettype wire

//--- lowpower_pkg.sv
// package: constants and types shared by the halt and power-down control block
// assumes: one 10 MHz clock, synchronous active-high reset
package lowpower_pkg;
    localparam logic [7:0] halt_opcode = 8'h01;
    localparam logic [11:0] reset_vector = 12'h000;
    localparam int clock_mhz = 10;
    // least oscillator-restart settle time before internal logic is trusted, in us
    localparam int restart_settle_us = 10;
    localparam int restart_settle_cycles = restart_settle_us * clock_mhz;
    localparam logic [7:0] port_reset_value = 8'hff;
    localparam logic [7:0] bus_reset_value = 8'h00;

    typedef enum logic [2:0] {
        st_run = 3'b000,
        st_halt = 3'b001,
        st_step_after_halt = 3'b010,
        st_pd_ram = 3'b011,
        st_pd_all = 3'b100
    } mode_t;

    // an opcode equal to the halt code
    function automatic logic is_halt(input logic [7:0] op);
        return op == halt_opcode;
    endfunction
endpackage

//--- pin_hold.sv
// pin hold: latches core pin values, keeps them while frozen, floats them in power-down
// assumes: core values arrive on the same clock
`timescale 1ns/100ps
`default_nettype none
module pin_hold
    import lowpower_pkg::*;
#(
    parameter int width = 8
) (
    input wire logic clock,
    input wire logic rst,
    freeze_if.hold fz,
    input wire logic [width-1:0] core_value,
    input wire logic core_enable,
    input wire logic [width-1:0] reset_value,
    output logic [width-1:0] pin_out,
    output logic pin_oe
);
    initial begin
        if (width < 1) begin
            $error("pin_hold: width must be at least one");
        end
    end

    // hold value follows core while running, freezes while clocks are stopped
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_out <= reset_value;
        end else if (!fz.clocks_stopped && fz.resume_vector) begin
            // restart from ram retention shows reset levels until reset is released
            pin_out <= reset_value;
        end else if (!fz.clocks_stopped) begin
            pin_out <= core_value;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_oe <= 1'b0;
        end else if (fz.pins_floated) begin
            pin_oe <= 1'b0;
        end else if (!fz.clocks_stopped) begin
            pin_oe <= core_enable;
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
// testbench: halt release paths and both power-down modes at the block's ports
// assumes: board_model drives the board pins; the checker is bound to the block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import lowpower_pkg::*;
;
    logic clock, rst, reset_n_pin, single_step_n_pin, power_save_n_pin, interrupt_n_pin;
    logic test_pin_zero_in, exec_strobe, enable_interrupts, disable_interrupts;
    logic core_data_bus_oe, core_test_pin_zero, core_test_pin_zero_oe;
    logic [7:0] exec_opcode, core_data_bus, core_port_one, core_port_two;
    logic core_clock_enable, core_reset, take_interrupt, interrupts_enabled_state;
    logic oscillator_run, reset_pullup_on, step_pullup_on, test_pin_zero_sampled;
    logic data_bus_lines_oe, port_one_lines_oe, port_two_lines_oe;
    logic test_pin_zero_out, test_pin_zero_oe, seen;
    logic [7:0] data_bus_lines_out, port_one_lines_out, port_two_lines_out;
    logic [11:0] restart_address;
    mode_t mode;
    int bad_count, n_checks;
    halt_and_power_down_control i_dut (
        .clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
        .single_step_n_pin(single_step_n_pin), .power_save_n_pin(power_save_n_pin),
        .interrupt_n_pin(interrupt_n_pin), .test_pin_zero_in(test_pin_zero_in),
        .exec_strobe(exec_strobe), .exec_opcode(exec_opcode),
        .enable_interrupts(enable_interrupts), .disable_interrupts(disable_interrupts),
        .core_data_bus(core_data_bus), .core_data_bus_oe(core_data_bus_oe),
        .core_port_one(core_port_one), .core_port_two(core_port_two),
        .core_test_pin_zero(core_test_pin_zero), .core_test_pin_zero_oe(core_test_pin_zero_oe),
        .core_clock_enable(core_clock_enable), .core_reset(core_reset),
        .restart_address(restart_address), .take_interrupt(take_interrupt),
        .interrupts_enabled_state(interrupts_enabled_state), .oscillator_run(oscillator_run),
        .reset_pullup_on(reset_pullup_on), .step_pullup_on(step_pullup_on),
        .test_pin_zero_sampled(test_pin_zero_sampled),
        .data_bus_lines_out(data_bus_lines_out), .data_bus_lines_oe(data_bus_lines_oe),
        .port_one_lines_out(port_one_lines_out), .port_one_lines_oe(port_one_lines_oe),
        .port_two_lines_out(port_two_lines_out), .port_two_lines_oe(port_two_lines_oe),
        .test_pin_zero_out(test_pin_zero_out), .test_pin_zero_oe(test_pin_zero_oe),
        .mode(mode)
    );
    // the long power-save setup time is shortened to keep the run brief
    board_model #(.setup_cycles(50)) b (
        .clock(clock), .reset_n_pin(reset_n_pin), .single_step_n_pin(single_step_n_pin),
        .power_save_n_pin(power_save_n_pin), .interrupt_n_pin(interrupt_n_pin)
    );
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input mode_t m);
        for (int i = 0; i < 20 && mode !== m; i++) tick(1);
        chk(16'(mode), 16'(m));
    endtask
    task automatic exec(input logic [7:0] op);
        exec_opcode = op;
        exec_strobe = 1'h1;
        tick(1);
        exec_strobe = 1'h0;
    endtask
    task automatic halt_wake(input logic [7:0] v, input logic [1:0] pins, input mode_t m);
        {core_port_one, core_port_two, core_data_bus, core_test_pin_zero} = {v, ~v, v, v[0]};
        tick(3);
        exec(halt_opcode);
        chk(16'(mode), 16'(st_halt));
        chk(core_clock_enable, 1'h0);
        {core_port_one, core_port_two, core_data_bus, core_test_pin_zero} = {~v, v, ~v, ~v[0]};
        tick(4);
        chk({port_two_lines_out, port_one_lines_out}, {~v, v});
        chk({data_bus_lines_out, 7'h0, test_pin_zero_out}, {v, 7'h0, v[0]});
        chk({data_bus_lines_oe, port_one_lines_oe, port_two_lines_oe, test_pin_zero_oe}, 4'hf);
        b.drive(pins);
        wait_mode(m);
    endtask
    task automatic t_halt_di;
        chk(interrupts_enabled_state, 1'h0);
        enable_interrupts = 1'h1;
        tick(1);
        {enable_interrupts, disable_interrupts} = 2'h1;
        tick(1);
        disable_interrupts = 1'h0;
        chk(interrupts_enabled_state, 1'h0);
        halt_wake(8'h5a, 2'h2, st_run);
        tick(2);
        chk({take_interrupt, port_one_lines_out}, {1'h0, 8'ha5});
        b.drive(2'h3);
    endtask
    task automatic t_halt_ei;
        enable_interrupts = 1'h1;
        tick(1);
        enable_interrupts = 1'h0;
        halt_wake(8'h3c, 2'h2, st_step_after_halt);
        chk(take_interrupt, 1'h0);
        exec(8'h00);
        seen = take_interrupt;
        tick(1);
        chk(seen | take_interrupt, 1'h1);
        b.drive(2'h3);
    endtask
    task automatic t_halt_reset;
        halt_wake(8'hc3, 2'h1, st_run);
        chk({core_reset, restart_address}, {1'h1, reset_vector});
        b.drive(2'h3);
        tick(4);
        chk({core_reset, interrupts_enabled_state}, 2'h0);
    endtask
    task automatic t_pd(input logic ram);
        enable_interrupts = !ram;
        tick(1);
        enable_interrupts = 1'h0;
        b.enter_pd(ram);
        wait_mode(ram ? st_pd_ram : st_pd_all);
        seen = test_pin_zero_sampled;
        test_pin_zero_in = ~test_pin_zero_in;
        // reset stays low through ram retention; in full retention it must be ignored
        b.drive(2'h1);
        tick(4);
        chk({oscillator_run, reset_pullup_on, step_pullup_on, test_pin_zero_oe}, 4'h0);
        chk({test_pin_zero_sampled, core_reset}, {seen, ram});
        if (!ram) begin
            b.drive(2'h3);
        end
        b.leave_pd;
        wait_mode(st_run);
        chk({restart_address, interrupts_enabled_state}, {reset_vector, !ram});
        tick(4);
        chk({core_reset, oscillator_run}, 2'h1);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {rst, exec_strobe, enable_interrupts, disable_interrupts} = 4'h8;
        {exec_opcode, core_data_bus, core_port_one, core_port_two} = 32'h0;
        {core_data_bus_oe, core_test_pin_zero, core_test_pin_zero_oe, test_pin_zero_in} = 4'hf;
        bad_count = 0;
        n_checks = 0;
        tick(8);
        rst = 1'h0;
        tick(2);
        t_halt_di;
        t_halt_ei;
        t_halt_reset;
        t_pd(1'h1);
        t_pd(1'h0);
        print_verdict;
    end
    initial begin
        tick(5000);
        bad_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
